// [hdl/cfs_pkg.sv]
// Purpose: Constants for the CPU condition flags and stack pointer block.
// Assumes: One clock, asynchronous active-low reset, plain register port.
// Notes:   Register port offsets are word indexes on the plain port.
//
// Overview of operation
// (RULE1) Add and add-with-carry set half carry at bit 4 from bit-3 carry.
// (RULE2) Negative flag bit 2 copies result bit 7 after every data operation.
// (RULE3) Zero flag bit 1 is set when the result is zero, else cleared.
// (RULE4) Carry flag bit 0 follows arithmetic overflow or underflow.
// (RULE5) Carry is set, reset, and updated by bit-test, shift and rotate.
// (RULE6) Branch conditions test each flag in both polarities.
// (RULE7) Priority bits sit at bit 5 (high) and bit 3 (low).
// (RULE8) Pair 10 is level 0, 01 level 1, 00 level 2, 11 disabled.
// (RULE9) Interrupt entry loads both priority bits from the interrupt's field.
// (RULE10) Enable, disable, return, halt, wait and pop also change priority bits.
// (RULE11) The whole 8-bit condition register is pushed and popped.
// (RULE12) Pointer addresses next free byte; decrement after push, increment before pop.
// (RULE13) Upper pointer byte is forced; only the low byte varies.
// (RULE14) Reset or reset-stack instruction sets the low pointer byte to all ones.
// (RULE15) The low pointer byte is readable and writable by a load instruction.
// (RULE16) Pointer wraps silently at both stack limits.
// (RULE17) Interrupt entry stores program counter low first, at the pointer.
// (RULE18) A call uses two stack bytes, an interrupt five.
// (RULE19) The second index register is never part of interrupt context.
// (RULE20) Context order: pc low, pc high, index, accumulator, flags; popped in reverse.
// (RULE21) Flag bits 7 and 6 read as one and ignore writes.
package cfs_pkg;
    localparam int unsigned BIT_CARRY    = 0;
    localparam int unsigned BIT_ZERO     = 1;
    localparam int unsigned BIT_NEG      = 2;
    localparam int unsigned BIT_PRIO_LO  = 3;
    localparam int unsigned BIT_HALF     = 4;
    localparam int unsigned BIT_PRIO_HI  = 5;
    localparam logic [7:0]  FLAGS_FIXED  = 8'hc0;
    localparam logic [7:0]  FLAGS_RESET  = 8'he8;
    localparam logic [7:0]  STACK_HIGH   = 8'h01;
    localparam logic [7:0]  STACK_TOP    = 8'hff;
    localparam logic [1:0]  PRIO_MAIN    = 2'h2;
    localparam logic [1:0]  PRIO_LVL1    = 2'h1;
    localparam logic [1:0]  PRIO_LVL2    = 2'h0;
    localparam logic [1:0]  PRIO_OFF     = 2'h3;
    localparam logic [2:0]  CTX_BYTES    = 3'h5;
    localparam logic [2:0]  CALL_BYTES   = 3'h2;
    localparam logic [1:0]  ADDR_FLAGS   = 2'h0;
    localparam logic [1:0]  ADDR_SP_LO   = 2'h1;
    localparam logic [1:0]  ADDR_SP_HI   = 2'h2;
    localparam logic [1:0]  ADDR_PRIO    = 2'h3;

    // Flag operations requested by the decoder.
    typedef enum logic [3:0] {
        CFS_OP_NONE  = 4'h0,
        CFS_OP_ADD   = 4'h1,
        CFS_OP_ARITH = 4'h2,
        CFS_OP_LOGIC = 4'h3,
        CFS_OP_SHIFT = 4'h4,
        CFS_OP_BTEST = 4'h5,
        CFS_OP_SETC  = 4'h6,
        CFS_OP_CLRC  = 4'h7,
        CFS_OP_IEN   = 4'h8,
        CFS_OP_IDIS  = 4'h9,
        CFS_OP_HALT  = 4'ha,
        CFS_OP_LOAD  = 4'hb
    } cfs_op_e;

    // Branch conditions.
    typedef enum logic [2:0] {
        CFS_BR_HALF   = 3'h0,
        CFS_BR_NOHALF = 3'h1,
        CFS_BR_MINUS  = 3'h2,
        CFS_BR_PLUS   = 3'h3,
        CFS_BR_EQ     = 3'h4,
        CFS_BR_NE     = 3'h5,
        CFS_BR_CARRY  = 3'h6,
        CFS_BR_NOCARRY = 3'h7
    } cfs_br_e;

    // Stack sequencer states.
    typedef enum logic [2:0] {
        CFS_ST_IDLE  = 3'h0,
        CFS_ST_PUSH  = 3'h1,
        CFS_ST_POP   = 3'h2
    } cfs_st_e;

    // Stack request kinds.
    typedef enum logic [2:0] {
        CFS_SK_NONE  = 3'h0,
        CFS_SK_IRQ   = 3'h1,
        CFS_SK_IEXIT = 3'h2,
        CFS_SK_CALL  = 3'h3,
        CFS_SK_RET   = 3'h4,
        CFS_SK_PUSHF = 3'h5,
        CFS_SK_POPF  = 3'h6
    } cfs_sk_e;
endpackage : cfs_pkg

// [hdl/cfs_flags_stack.sv]
// Purpose: Condition flags register and wrapping stack pointer with a
//          context sequencer that walks interrupt and call frames.
// Assumes: One clock; the memory write/read happens in the cycle the
//          sequencer asserts mem_we_out or mem_re_out; read data returns
//          one cycle later on mem_rdata_in.
// Notes:   One stack byte is moved per cycle; requests while busy are ignored.
//
// Local design decisions: the register addresses and strobed register access.
module cfs_flags_stack (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Decoder and ALU side.
    input  wire logic [3:0]  op_in,
    input  wire logic [7:0]  result_in,
    input  wire logic        carry_in,
    input  wire logic        half_in,
    input  wire logic [2:0]  branch_cond_in,
    output logic             branch_take_out,
    // Stack requests.
    input  wire logic [2:0]  stack_req_in,
    input  wire logic [1:0]  irq_prio_in,
    input  wire logic        reset_stack_in,
    input  wire logic [7:0]  pc_low_in,
    input  wire logic [7:0]  pc_high_in,
    input  wire logic [7:0]  index_in,
    input  wire logic [7:0]  accum_in,
    output logic             busy_out,
    output logic             done_out,
    output logic [7:0]       pc_low_out,
    output logic [7:0]       pc_high_out,
    output logic [7:0]       index_out,
    output logic [7:0]       accum_out,
    // Stack memory port.
    output logic [15:0]      mem_addr_out,
    output logic [7:0]       mem_wdata_out,
    output logic             mem_we_out,
    output logic             mem_re_out,
    input  wire logic [7:0]  mem_rdata_in,
    // Register port.
    input  wire logic [1:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [7:0]       reg_rdata_out,
    // Current state.
    output logic [7:0]       flags_out,
    output logic [15:0]      stack_pointer_out
);
    logic [7:0]  flags_q;
    logic [7:0]  sp_lo_q;
    logic [1:0]  prio_q;
    cfs_pkg::cfs_st_e st_q;
    cfs_pkg::cfs_sk_e kind_q;
    logic [2:0]  cnt_q;
    logic [2:0]  len_q;
    logic        rd_pend_q;
    logic [2:0]  rd_idx_q;
    logic [7:0]  ctx_q [5];
    logic [7:0]  flags_w;
    logic [7:0]  push_byte;
    logic [2:0]  sk_len;
    logic        start_push;
    logic        start_pop;
    logic        pop_flags_now;

    // Bits 7 and 6 are constants so software cannot disturb them.
    assign flags_w           = flags_q | cfs_pkg::FLAGS_FIXED; // RULE21
    assign flags_out         = flags_w;
    assign stack_pointer_out = {cfs_pkg::STACK_HIGH, sp_lo_q}; // RULE13
    assign busy_out          = (st_q != cfs_pkg::CFS_ST_IDLE) || rd_pend_q;

    // Branch decision from the stored flags, both polarities per flag.
    always_comb begin
        unique case (cfs_pkg::cfs_br_e'(branch_cond_in)) // RULE6
            cfs_pkg::CFS_BR_HALF:    branch_take_out = flags_q[cfs_pkg::BIT_HALF];
            cfs_pkg::CFS_BR_NOHALF:  branch_take_out = !flags_q[cfs_pkg::BIT_HALF];
            cfs_pkg::CFS_BR_MINUS:   branch_take_out = flags_q[cfs_pkg::BIT_NEG];
            cfs_pkg::CFS_BR_PLUS:    branch_take_out = !flags_q[cfs_pkg::BIT_NEG];
            cfs_pkg::CFS_BR_EQ:      branch_take_out = flags_q[cfs_pkg::BIT_ZERO];
            cfs_pkg::CFS_BR_NE:      branch_take_out = !flags_q[cfs_pkg::BIT_ZERO];
            cfs_pkg::CFS_BR_CARRY:   branch_take_out = flags_q[cfs_pkg::BIT_CARRY];
            cfs_pkg::CFS_BR_NOCARRY: branch_take_out = !flags_q[cfs_pkg::BIT_CARRY];
        endcase
    end

    // Frame length per request kind.
    always_comb begin
        unique case (cfs_pkg::cfs_sk_e'(stack_req_in))
            cfs_pkg::CFS_SK_IRQ, cfs_pkg::CFS_SK_IEXIT: sk_len = cfs_pkg::CTX_BYTES; // RULE18
            cfs_pkg::CFS_SK_CALL, cfs_pkg::CFS_SK_RET: sk_len = cfs_pkg::CALL_BYTES; // RULE18
            cfs_pkg::CFS_SK_PUSHF, cfs_pkg::CFS_SK_POPF: sk_len = 3'h1;
            default: sk_len = 3'h0;
        endcase
    end

    assign start_push = !busy_out && (stack_req_in == cfs_pkg::CFS_SK_IRQ
                      || stack_req_in == cfs_pkg::CFS_SK_CALL
                      || stack_req_in == cfs_pkg::CFS_SK_PUSHF);
    assign start_pop  = !busy_out && (stack_req_in == cfs_pkg::CFS_SK_IEXIT
                      || stack_req_in == cfs_pkg::CFS_SK_RET
                      || stack_req_in == cfs_pkg::CFS_SK_POPF);

    // Byte to push: pc low first, then pc high, index, accumulator, flags.
    // The second index register has no input here and is never saved.
    always_comb begin
        if (kind_q == cfs_pkg::CFS_SK_PUSHF) begin
            push_byte = flags_w; // RULE11
        end else begin
            push_byte = ctx_q[cnt_q]; // RULE20 RULE19
        end
    end

    // Memory strobes; push writes at the pointer, pop reads at pointer plus one.
    always_comb begin
        mem_we_out    = (st_q == cfs_pkg::CFS_ST_PUSH);
        mem_re_out    = (st_q == cfs_pkg::CFS_ST_POP);
        mem_wdata_out = push_byte;
        if (st_q == cfs_pkg::CFS_ST_POP) begin
            mem_addr_out = {cfs_pkg::STACK_HIGH, sp_lo_q + 8'h01}; // RULE12
        end else begin
            mem_addr_out = {cfs_pkg::STACK_HIGH, sp_lo_q}; // RULE17
        end
    end

    // Sequencer state and frame counter.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q   <= cfs_pkg::CFS_ST_IDLE;
            kind_q <= cfs_pkg::CFS_SK_NONE;
            cnt_q  <= 3'h0;
            len_q  <= 3'h0;
        end else begin
            unique case (st_q)
                cfs_pkg::CFS_ST_IDLE: begin
                    cnt_q <= 3'h0;
                    if (start_push || start_pop) begin
                        st_q   <= start_push ? cfs_pkg::CFS_ST_PUSH : cfs_pkg::CFS_ST_POP;
                        kind_q <= cfs_pkg::cfs_sk_e'(stack_req_in);
                        len_q  <= sk_len;
                    end
                end
                cfs_pkg::CFS_ST_PUSH, cfs_pkg::CFS_ST_POP: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q + 3'h1 == len_q) begin
                        st_q <= cfs_pkg::CFS_ST_IDLE;
                    end
                end
                default: st_q <= cfs_pkg::CFS_ST_IDLE;
            endcase
        end
    end

    // Snapshot of the context taken when a push frame starts.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 5; i++) begin
                ctx_q[i] <= 8'h00;
            end
        end else if (start_push) begin
            ctx_q[0] <= pc_low_in;
            ctx_q[1] <= pc_high_in;
            ctx_q[2] <= index_in;
            ctx_q[3] <= accum_in;
            ctx_q[4] <= flags_w;
        end
    end

    // Pop data arrives one cycle after the read; slot index counts down so
    // the frame comes back in reverse order of the push.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_pend_q <= 1'b0;
            rd_idx_q  <= 3'h0;
            done_out  <= 1'b0;
        end else begin
            rd_pend_q <= (st_q == cfs_pkg::CFS_ST_POP);
            rd_idx_q  <= (kind_q == cfs_pkg::CFS_SK_POPF) ? 3'h4
                       : len_q - 3'h1 - cnt_q; // RULE20
            done_out  <= (st_q == cfs_pkg::CFS_ST_PUSH && cnt_q + 3'h1 == len_q)
                       || (rd_pend_q && st_q == cfs_pkg::CFS_ST_IDLE);
        end
    end

    // Restored context outputs.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pc_low_out  <= 8'h00;
            pc_high_out <= 8'h00;
            index_out   <= 8'h00;
            accum_out   <= 8'h00;
        end else if (rd_pend_q) begin
            unique case (rd_idx_q)
                3'h0: pc_low_out  <= mem_rdata_in;
                3'h1: pc_high_out <= mem_rdata_in;
                3'h2: index_out   <= mem_rdata_in;
                3'h3: accum_out   <= mem_rdata_in;
                default: ;
            endcase
        end
    end

    assign pop_flags_now = rd_pend_q && rd_idx_q == 3'h4;

    // Stack pointer low byte; upper byte is fixed, so plain 8-bit
    // arithmetic gives the silent wrap at both limits.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sp_lo_q <= cfs_pkg::STACK_TOP; // RULE14
        end else if (reset_stack_in) begin
            sp_lo_q <= cfs_pkg::STACK_TOP; // RULE14
        end else if (st_q == cfs_pkg::CFS_ST_PUSH) begin
            sp_lo_q <= sp_lo_q - 8'h01; // RULE12 RULE16
        end else if (st_q == cfs_pkg::CFS_ST_POP) begin
            sp_lo_q <= sp_lo_q + 8'h01; // RULE12 RULE16
        end else if (reg_wr_in && reg_addr_in == cfs_pkg::ADDR_SP_LO) begin
            sp_lo_q <= reg_wdata_in; // RULE15
        end
    end

    // Condition flags: pop, then register write, then interrupt entry, then decoder operations.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flags_q <= cfs_pkg::FLAGS_RESET;
        end else if (pop_flags_now) begin
            flags_q <= mem_rdata_in | cfs_pkg::FLAGS_FIXED; // RULE11 RULE10
        end else if (reg_wr_in && reg_addr_in == cfs_pkg::ADDR_FLAGS) begin
            flags_q <= reg_wdata_in | cfs_pkg::FLAGS_FIXED; // RULE21
        end else if (start_push && stack_req_in == cfs_pkg::CFS_SK_IRQ) begin
            flags_q[cfs_pkg::BIT_PRIO_HI] <= irq_prio_in[1]; // RULE9 RULE7
            flags_q[cfs_pkg::BIT_PRIO_LO] <= irq_prio_in[0]; // RULE9 RULE7
        end else begin
            unique case (cfs_pkg::cfs_op_e'(op_in))
                cfs_pkg::CFS_OP_ADD: begin
                    flags_q[cfs_pkg::BIT_HALF]  <= half_in; // RULE1
                    flags_q[cfs_pkg::BIT_NEG]   <= result_in[7]; // RULE2
                    flags_q[cfs_pkg::BIT_ZERO]  <= result_in == 8'h00; // RULE3
                    flags_q[cfs_pkg::BIT_CARRY] <= carry_in; // RULE4
                end
                cfs_pkg::CFS_OP_ARITH, cfs_pkg::CFS_OP_SHIFT: begin
                    flags_q[cfs_pkg::BIT_NEG]   <= result_in[7]; // RULE2
                    flags_q[cfs_pkg::BIT_ZERO]  <= result_in == 8'h00; // RULE3
                    flags_q[cfs_pkg::BIT_CARRY] <= carry_in; // RULE4 RULE5
                end
                cfs_pkg::CFS_OP_LOGIC, cfs_pkg::CFS_OP_LOAD: begin
                    flags_q[cfs_pkg::BIT_NEG]   <= result_in[7]; // RULE2
                    flags_q[cfs_pkg::BIT_ZERO]  <= result_in == 8'h00; // RULE3
                end
                cfs_pkg::CFS_OP_BTEST: flags_q[cfs_pkg::BIT_CARRY] <= carry_in; // RULE5
                cfs_pkg::CFS_OP_SETC:  flags_q[cfs_pkg::BIT_CARRY] <= 1'b1; // RULE5
                cfs_pkg::CFS_OP_CLRC:  flags_q[cfs_pkg::BIT_CARRY] <= 1'b0; // RULE5
                cfs_pkg::CFS_OP_IEN, cfs_pkg::CFS_OP_HALT: begin
                    flags_q[cfs_pkg::BIT_PRIO_HI] <= cfs_pkg::PRIO_MAIN[1]; // RULE10 RULE8
                    flags_q[cfs_pkg::BIT_PRIO_LO] <= cfs_pkg::PRIO_MAIN[0]; // RULE10 RULE8
                end
                cfs_pkg::CFS_OP_IDIS: begin
                    flags_q[cfs_pkg::BIT_PRIO_HI] <= cfs_pkg::PRIO_OFF[1]; // RULE10 RULE8
                    flags_q[cfs_pkg::BIT_PRIO_LO] <= cfs_pkg::PRIO_OFF[0]; // RULE10 RULE8
                end
                default: ;
            endcase
        end
    end

    // Read data one cycle after the read strobe; cycles without a read strobe give zero.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                cfs_pkg::ADDR_FLAGS: reg_rdata_out <= flags_w;
                cfs_pkg::ADDR_SP_LO: reg_rdata_out <= sp_lo_q; // RULE15
                cfs_pkg::ADDR_SP_HI: reg_rdata_out <= cfs_pkg::STACK_HIGH;
                cfs_pkg::ADDR_PRIO:  reg_rdata_out <= {6'h00,
                    flags_q[cfs_pkg::BIT_PRIO_HI], flags_q[cfs_pkg::BIT_PRIO_LO]};
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end
endmodule : cfs_flags_stack

// [dv/cfs_flags_stack_props.sv]
// Purpose: Concurrent checks on the ports of the flags and stack block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Bound to every instance of cfs_flags_stack.
module cfs_flags_stack_props (
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic [3:0]  op_in,
    input wire logic [7:0]  result_in,
    input wire logic        half_in,
    input wire logic [2:0]  branch_cond_in,
    input wire logic        branch_take_out,
    input wire logic [2:0]  stack_req_in,
    input wire logic        reset_stack_in,
    input wire logic [7:0]  pc_low_in,
    input wire logic        busy_out,
    input wire logic        done_out,
    input wire logic [15:0] mem_addr_out,
    input wire logic [7:0]  mem_wdata_out,
    input wire logic        mem_we_out,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [7:0]  flags_out,
    input wire logic [15:0] stack_pointer_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    // A flag operation counts only when no register write or frame owns the flags.
    logic op_free;
    logic flag_op;
    assign op_free = !reg_wr_in && !busy_out && stack_req_in == cfs_pkg::CFS_SK_NONE;
    assign flag_op = op_free && op_in inside {cfs_pkg::CFS_OP_ADD, cfs_pkg::CFS_OP_ARITH,
                                              cfs_pkg::CFS_OP_LOGIC, cfs_pkg::CFS_OP_LOAD};

    // Interrupt entry is a request, five writes and then the end pulse.
    sequence irq_start;
        stack_req_in == cfs_pkg::CFS_SK_IRQ && !busy_out;
    endsequence
    sequence push5;
        mem_we_out [*5] ##1 done_out;
    endsequence

    chk_fixed_ones: assert property (flags_out[7:6] == 2'b11)
        else $error("unused flag bits not one");
    chk_sp_upper: assert property (stack_pointer_out[15:8] == cfs_pkg::STACK_HIGH)
        else $error("stack pointer high byte moved");
    chk_neg_copy: assert property (flag_op |=> flags_out[2] == $past(result_in[7]))
        else $error("negative flag differs from result sign");
    chk_zero_flag: assert property (flag_op |=> flags_out[1] == !$past(result_in))
        else $error("zero flag differs from result");
    chk_half_add: assert property (op_free && op_in == cfs_pkg::CFS_OP_ADD
        |=> flags_out[4] == $past(half_in)) else $error("half carry not taken on add");
    chk_carry_set: assert property (op_free && op_in == cfs_pkg::CFS_OP_SETC
        |=> flags_out[0]) else $error("carry not set");
    chk_prio_off: assert property (op_free && op_in == cfs_pkg::CFS_OP_IDIS
        |=> flags_out[5] && flags_out[3]) else $error("priority not disabled");
    chk_branch_eq: assert property (branch_cond_in == cfs_pkg::CFS_BR_EQ
        |-> branch_take_out == flags_out[1]) else $error("equal branch wrong");
    chk_rsp_top: assert property (reset_stack_in && !busy_out
        |=> stack_pointer_out[7:0] == 8'hff) else $error("stack reset missed");
    chk_irq_frame: assert property (irq_start |=> push5)
        else $error("interrupt frame not five writes");
    chk_pcl_first: assert property (irq_start |=> mem_wdata_out == $past(pc_low_in)
        && mem_addr_out == $past(stack_pointer_out)) else $error("first push not pc low");
    chk_irq_sp: assert property (irq_start |-> ##6
        (($past(stack_pointer_out, 6) - stack_pointer_out) & 16'h00ff) == 16'h0005)
        else $error("pointer not five lower after entry");
    chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside read slot");
endmodule : cfs_flags_stack_props

bind cfs_flags_stack cfs_flags_stack_props u_props (.*);

// [dv/testbench.sv]
// Purpose: Self-checking bench for the flags and stack pointer block.
// Assumes: The bench is register master and stack memory.
// Notes:   Flag rows run in one loop; frames, wrap and resets follow.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        cfs_pkg::cfs_op_e op;
        logic [7:0]       res;
        logic             cy;
        logic             hc;
        logic [7:0]       mask;
        logic [7:0]       exp;
    } cfs_row_s;

    localparam logic [15:0] EA [5] = '{16'h0102, 16'h0101, 16'h0100, 16'h01ff, 16'h01fe};
    localparam logic [7:0]  ED [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hd5};

    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [3:0]  op_in = 4'h0;
    logic [7:0]  result_in = 8'h00;
    logic        carry_in = 1'b0;
    logic        half_in = 1'b0;
    logic [2:0]  branch_cond_in = 3'h0;
    logic [2:0]  stack_req_in = 3'h0;
    logic [1:0]  irq_prio_in = 2'h0;
    logic        reset_stack_in = 1'b0;
    logic [7:0]  pc_low_in = 8'h11;
    logic [7:0]  pc_high_in = 8'h22;
    logic [7:0]  index_in = 8'h33;
    logic [7:0]  accum_in = 8'h44;
    logic [7:0]  mem_rdata_in = 8'h00;
    logic [1:0]  reg_addr_in = 2'h0;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        branch_take_out, busy_out, done_out, mem_we_out, mem_re_out;
    logic [7:0]  pc_low_out, pc_high_out, index_out, accum_out;
    logic [7:0]  mem_wdata_out, reg_rdata_out, flags_out, rd_val;
    logic [15:0] mem_addr_out, stack_pointer_out;
    logic [7:0]  mem [256];
    logic [15:0] wa [$];
    logic [7:0]  wd [$];
    cfs_row_s    rows [13];
    int          errors = 0;
    int          check_count = 0;

    cfs_flags_stack uut (.*);

    // Half period of 4 ns gives 125 MHz.
    always #4 clk_in = ~clk_in;

    // Stack memory; an idle read bus shows the inverse of its last value.
    always @(posedge clk_in) begin
        if (mem_we_out) begin
            mem[mem_addr_out[7:0]] <= mem_wdata_out;
            wa.push_back(mem_addr_out);
            wd.push_back(mem_wdata_out);
        end
        mem_rdata_in <= mem_re_out ? mem[mem_addr_out[7:0]] : ~mem_rdata_in;
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask : reg_wr

    // Read data stands only in the cycle after the strobe, so it is taken there.
    task automatic reg_rd(input logic [1:0] a);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1 rd_val = reg_rdata_out;
    endtask : reg_rd

    // One-cycle request, then a bounded wait for the end pulse.
    task automatic stack_op(input cfs_pkg::cfs_sk_e req);
        int n = 0;
        @(posedge clk_in);
        stack_req_in <= req;
        @(posedge clk_in);
        stack_req_in <= cfs_pkg::CFS_SK_NONE;
        #1;
        while (done_out !== 1'b1 && n < 20) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n == 20) check("frame end", 16'h0001, 16'h0000);
    endtask : stack_op

    // Branch outcome from flags: pairs test half, negative, zero, carry; odd codes invert.
    function automatic logic br_exp(input logic [7:0] f, input int c);
        logic [3:0] sel;
        sel = {f[0], f[1], f[2], f[4]};
        return sel[c / 2] ^ c[0];
    endfunction : br_exp

    // Watchdog; the whole run needs about a hundred cycles.
    initial begin
        repeat (3000) @(posedge clk_in);
        errors++;
        $display("[FAIL] watchdog expected end seen hang");
        final_report();
    end

    initial begin
        rows = '{'{cfs_pkg::CFS_OP_ADD, 8'h00, 1'b1, 1'b1, 8'h17, 8'h13},
                 '{cfs_pkg::CFS_OP_ADD, 8'h80, 1'b0, 1'b0, 8'h17, 8'h04},
                 '{cfs_pkg::CFS_OP_ARITH, 8'h7f, 1'b1, 1'b0, 8'h07, 8'h01},
                 '{cfs_pkg::CFS_OP_LOGIC, 8'h00, 1'b0, 1'b0, 8'h06, 8'h02},
                 '{cfs_pkg::CFS_OP_LOAD, 8'hff, 1'b0, 1'b0, 8'h06, 8'h04},
                 '{cfs_pkg::CFS_OP_SHIFT, 8'h00, 1'b1, 1'b0, 8'h01, 8'h01},
                 '{cfs_pkg::CFS_OP_BTEST, 8'h00, 1'b0, 1'b0, 8'h01, 8'h00},
                 '{cfs_pkg::CFS_OP_SETC, 8'h00, 1'b0, 1'b0, 8'h01, 8'h01},
                 '{cfs_pkg::CFS_OP_CLRC, 8'h00, 1'b0, 1'b0, 8'h01, 8'h00},
                 '{cfs_pkg::CFS_OP_IDIS, 8'h00, 1'b0, 1'b0, 8'h28, 8'h28},
                 '{cfs_pkg::CFS_OP_IEN, 8'h00, 1'b0, 1'b0, 8'h28, 8'h20},
                 '{cfs_pkg::CFS_OP_IDIS, 8'h00, 1'b0, 1'b0, 8'h28, 8'h28},
                 '{cfs_pkg::CFS_OP_HALT, 8'h00, 1'b0, 1'b0, 8'h28, 8'h20}};
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1 check("flags at reset", 16'h00e8, {8'h00, flags_out});
        check("sp at reset", 16'h01ff, stack_pointer_out);
        foreach (rows[i]) begin
            @(posedge clk_in);
            op_in     <= rows[i].op;
            result_in <= rows[i].res;
            carry_in  <= rows[i].cy;
            half_in   <= rows[i].hc;
            @(posedge clk_in);
            op_in <= cfs_pkg::CFS_OP_NONE;
            #1 check("flags", 16'(rows[i].exp),
                     16'(flags_out & rows[i].mask));
            if (rows[i].mask == 8'h17) begin
                for (int c = 0; c < 8; c++) begin
                    @(posedge clk_in);
                    branch_cond_in <= 3'(c);
                    #1 check("branch", 16'(br_exp(rows[i].exp, c)), 16'(branch_take_out));
                end
            end
        end
        reg_rd(cfs_pkg::ADDR_SP_HI);
        check("sp high", 16'h0001, {8'h00, rd_val});
        reg_wr(cfs_pkg::ADDR_FLAGS, 8'h20);
        reg_rd(cfs_pkg::ADDR_FLAGS);
        check("flags write", 16'h00e0, {8'h00, rd_val});
        reg_rd(cfs_pkg::ADDR_PRIO);
        check("prio pair", 16'h0002, {14'h0, rd_val[1:0]});
        reg_wr(cfs_pkg::ADDR_SP_LO, 8'h02);
        reg_rd(cfs_pkg::ADDR_SP_LO);
        check("sp low", 16'h0002, {8'h00, rd_val});
        // Entry from pointer 02 crosses the lower stack limit.
        reg_wr(cfs_pkg::ADDR_FLAGS, 8'h15);
        irq_prio_in <= 2'h1;
        stack_op(cfs_pkg::CFS_SK_IRQ);
        check("push count", 16'h0005, 16'(wa.size()));
        foreach (EA[i]) begin
            check("push addr", EA[i], wa[i]);
            check("push data", {8'h00, ED[i]}, {8'h00, wd[i]});
        end
        check("sp after irq", 16'h01fd, stack_pointer_out);
        check("flags after irq", 16'h00dd, {8'h00, flags_out});
        reg_wr(cfs_pkg::ADDR_FLAGS, 8'h00);
        pc_low_in  <= 8'haa;
        pc_high_in <= 8'hbb;
        stack_op(cfs_pkg::CFS_SK_IEXIT);
        check("pop pc", 16'h2211, {pc_high_out, pc_low_out});
        check("pop x a", 16'h3344, {index_out, accum_out});
        check("flags after interrupt_return_instr", 16'h00d5, {8'h00, flags_out});
        check("sp after interrupt_return_instr", 16'h0102, stack_pointer_out);
        stack_op(cfs_pkg::CFS_SK_CALL);
        check("sp after call", 16'h0100, stack_pointer_out);
        stack_op(cfs_pkg::CFS_SK_RET);
        check("ret pc", 16'hbbaa, {pc_high_out, pc_low_out});
        stack_op(cfs_pkg::CFS_SK_PUSHF);
        reg_wr(cfs_pkg::ADDR_FLAGS, 8'h28);
        stack_op(cfs_pkg::CFS_SK_POPF);
        check("popped flags", 16'h00d5, {8'h00, flags_out});
        @(posedge clk_in);
        reset_stack_in <= 1'b1;
        @(posedge clk_in);
        reset_stack_in <= 1'b0;
        #1 check("sp after stack reset", 16'h01ff, stack_pointer_out);
        reg_wr(cfs_pkg::ADDR_SP_LO, 8'h10);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check("flags in reset", 16'h00e8, {8'h00, flags_out});
        check("sp in reset", 16'h01ff, stack_pointer_out);
        resetn_in <= 1'b1;
        #17 check("after reset", 16'h01ff, {busy_out, done_out, stack_pointer_out[13:0]});
        final_report();
    end
endmodule : testbench
